// ===== rtl/qpipe_defines.vh
// constants for the quad phase fetch/execute pipeline
// assumes inclusion by bare name from design files under rtl/ and from the checker under verification/
`ifndef QPIPE_DEFINES_VH
`define QPIPE_DEFINES_VH
`define PC_W 11
`define IW_W 12
`define DA_W 7
`define DD_W 8
`define PH_W 2
`define PH_ONE 2'h0
`define PH_TWO 2'h1
`define PH_THREE 2'h2
`define PH_FOUR 2'h3
`define PC_RESET 11'h7ff
`define IR_NOP 12'h000
`define PH_STEP 2'h1
`define PC_STEP 11'h001
`endif

// ===== rtl/sync2.v
// two flip-flop level synchroniser
// assumes the input may change at any time relative to clk_sys
`timescale 1ns/1ps
module sync2 (
  input wire clk_sys, // system clock
  input wire resetn, // asynchronous reset, active low
  input wire rst_val, // value taken under reset
  input wire async_in, // asynchronous level
  output wire sync_out // synchronised level
);
  reg meta_q;
  reg sync_q;
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= async_in;
      sync_q <= meta_q;
    end
  end
  // rst_val selects polarity at the output so the flops reset to constants
  assign sync_out = sync_q ^ rst_val;
endmodule // sync2

// ===== rtl/quad_phase_fetch_execute_pipeline.v
// quad phase clocking and two-stage fetch/execute pipeline control
// assumes clk_sys is the clock_in source; program memory answers combinationally
// assumes reset_n_pin and rc_mode are asynchronous pins; all other inputs come from clk_sys logic
`timescale 1ns/1ps
`include "qpipe_defines.vh"
module quad_phase_fetch_execute_pipeline (
  input wire clk_sys, // clock_in, 250 MHz
  input wire resetn, // asynchronous power-on reset, active low
  input wire reset_n_pin, // external reset pin, active low, asynchronous
  input wire rc_mode, // static mode strap, high selects rc oscillator mode
  output reg clock_out, // quarter-rate clock in rc mode, low otherwise
  output wire phase_one, // phase one strobe
  output wire phase_two, // phase two strobe
  output wire phase_three, // phase three strobe
  output wire phase_four, // phase four strobe
  output reg [`PC_W-1:0] prog_addr, // program memory address
  input wire [`IW_W-1:0] prog_data, // program memory word
  output reg [`IW_W-1:0] instr_word, // instruction register
  output reg instr_valid, // instruction register holds a real instruction
  output wire exec_active, // execute stage active in phases two to four
  output wire data_rd, // data memory operand read strobe
  output wire data_wr, // data memory destination write strobe
  input wire branch_req, // executing instruction redirects the program counter
  input wire [`PC_W-1:0] branch_target, // new program counter value
  input wire wr_req, // executing instruction writes a result
  output wire flush, // prefetched word discarded this cycle
  output wire in_reset // device held in reset
);
  // synchronised copies of the reset pin and the mode strap
  wire pin_rst_n;
  wire rc_sync;

  // phase generator state
  reg [`PH_W-1:0] phase_q;
  reg [`PH_W-1:0] phase_d;
  reg run_q;
  reg run_d;
  reg rc_q;
  reg rc_d;

  // fetch stage state
  reg [`PC_W-1:0] pc_q;
  reg [`PC_W-1:0] pc_d;
  reg [`PC_W-1:0] prog_addr_d;

  // execute stage and redirect state
  reg [`IW_W-1:0] instr_word_d;
  reg instr_valid_d;
  reg redirect_q;
  reg redirect_d;
  reg [`PC_W-1:0] target_q;
  reg [`PC_W-1:0] target_d;

  // quarter-rate clock pin
  reg clock_out_d;

  // decoded pipeline events
  wire fetch_start;
  wire fetch_end;
  wire branch_take;

  // the flops reset to the held level, so a pin that is low at power-up never lets the core run
  sync2 u_pin_sync (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .rst_val(1'b0),
    .async_in(reset_n_pin),
    .sync_out(pin_rst_n)
  );

  // the strap is used only while the pin holds the core, so a change during a run has no effect
  sync2 u_mode_sync (
    .clk_sys(clk_sys),
    .resetn(resetn),
    .rst_val(1'b0),
    .async_in(rc_mode),
    .sync_out(rc_sync)
  );

  // held while the pin is low and for the one rest cycle after release
  assign in_reset = ~pin_rst_n | ~run_q;

  // phase counter next state; one wrap of the counter is one instruction cycle
  always @* begin
    phase_d = phase_q;
    run_d = run_q;
    rc_d = rc_q;
    if (!pin_rst_n) begin
      phase_d = `PH_ONE;
      run_d = 1'b0;
      rc_d = rc_sync;
    end else begin
      run_d = 1'b1;
      if (run_q) begin
        phase_d = phase_q + `PH_STEP;
      end
    end
  end

  // phase registers
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      phase_q <= `PH_ONE;
      run_q <= 1'b0;
      rc_q <= 1'b0;
    end else begin
      phase_q <= phase_d;
      run_q <= run_d;
      rc_q <= rc_d;
    end
  end

  // one strobe per clock; all low while run_q is clear
  assign phase_one = run_q && (phase_q == `PH_ONE);
  assign phase_two = run_q && (phase_q == `PH_TWO);
  assign phase_three = run_q && (phase_q == `PH_THREE);
  assign phase_four = run_q && (phase_q == `PH_FOUR);

  // pipeline events shared by the fetch and execute stages
  assign fetch_start = phase_one;
  assign fetch_end = phase_four;
  assign branch_take = instr_valid && branch_req && phase_three;

  // execute stage works on instr_word while the next fetch proceeds
  // data strobes only for a real instruction, never for the start-up or flushed no-op
  assign exec_active = instr_valid && !phase_one;
  assign data_rd = instr_valid && phase_two;
  assign data_wr = instr_valid && phase_four && wr_req;
  assign flush = fetch_end && redirect_q;

  // pc, fetch address and instruction register next state
  always @* begin
    pc_d = pc_q;
    prog_addr_d = prog_addr;
    instr_word_d = instr_word;
    instr_valid_d = instr_valid;
    redirect_d = redirect_q;
    target_d = target_q;
    // held: the first running cycle then fetches with a no-op in the register
    if (in_reset) begin
      pc_d = `PC_RESET;
      prog_addr_d = `PC_RESET;
      instr_word_d = `IR_NOP;
      instr_valid_d = 1'b0;
      redirect_d = 1'b0;
      target_d = `PC_RESET;
    end else begin
      // phase_one loads the fetch address and steps the counter
      if (fetch_start) begin
        prog_addr_d = pc_q; // fetch address for this cycle
        pc_d = pc_q + `PC_STEP;
      end
      // target taken in phase_three and applied at the end of phase_four
      if (branch_take) begin
        redirect_d = 1'b1;
        target_d = branch_target;
      end
      // a pending redirect drops the prefetched word instead of latching it
      if (fetch_end) begin
        redirect_d = 1'b0;
        if (redirect_q) begin
          pc_d = target_q;
          instr_word_d = `IR_NOP;
          instr_valid_d = 1'b0;
        end else begin
          instr_word_d = prog_data;
          instr_valid_d = 1'b1;
        end
      end
    end
  end

  // pipeline registers
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      pc_q <= `PC_RESET;
      prog_addr <= `PC_RESET;
      instr_word <= `IR_NOP;
      instr_valid <= 1'b0;
      redirect_q <= 1'b0;
      target_q <= `PC_RESET;
    end else begin
      pc_q <= pc_d;
      prog_addr <= prog_addr_d;
      instr_word <= instr_word_d;
      instr_valid <= instr_valid_d;
      redirect_q <= redirect_d;
      target_q <= target_d;
    end
  end

  // clock_out follows the phase about to be entered, so it is high in phase_one and phase_two
  // low whenever rc mode is off or run_q is clear
  always @* begin
    clock_out_d = 1'b0;
    if (rc_q && run_d) begin
      if (phase_d == `PH_ONE || phase_d == `PH_TWO) begin
        clock_out_d = 1'b1;
      end
    end
  end

  // registered so the pin carries no decode glitches
  always @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      clock_out <= 1'b0;
    end else begin
      clock_out <= clock_out_d;
    end
  end
endmodule // quad_phase_fetch_execute_pipeline

// ===== verification/qpipe_chk.sv
// assertion checker for the quad phase pipeline
// assumes bind onto the pipeline top module
`timescale 1ns/1ps
`include "qpipe_defines.vh"
module qpipe_chk (
  input wire clk_sys, // clock
  input wire resetn, // reset
  input wire reset_n_pin, // pin reset
  input wire clock_out, // rc clock
  input wire phase_one, // p1
  input wire phase_two, // p2
  input wire phase_three, // p3
  input wire phase_four, // p4
  input wire [`PC_W-1:0] prog_addr, // address
  input wire [`IW_W-1:0] instr_word, // ir
  input wire instr_valid, // ir valid
  input wire exec_active, // execute window
  input wire data_rd, // read
  input wire data_wr, // write
  input wire branch_req, // redirect
  input wire [`PC_W-1:0] branch_target, // target
  input wire wr_req, // write req
  input wire flush, // flush
  input wire in_reset // held
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn || !reset_n_pin);
  chk_phase_seq: assert property (phase_one |=> phase_two ##1 phase_three ##1 phase_four ##1 phase_one)
    else $error("phase order");
  chk_pc_step: assert property (phase_four && !flush ##1 phase_one |=> prog_addr == $past(prog_addr, 2) + 1'b1)
    else $error("pc step");
  chk_addr_stand: assert property (phase_two |=> $stable(prog_addr)[*3])
    else $error("addr moved");
  chk_redirect_flush: assert property (phase_three && branch_req && instr_valid |=> flush ##1
    instr_word == `IR_NOP && !instr_valid ##1 prog_addr == $past(branch_target, 3)) else $error("redirect");
  chk_exec_span: assert property (instr_valid && phase_one |=> data_rd ##2 data_wr == wr_req)
    else $error("exec strobes");
  chk_no_strobe: assert property (!instr_valid |-> !data_rd && !data_wr)
    else $error("strobe on nop");
  chk_quarter_clk: assert property ($rose(clock_out) |=> clock_out ##1 !clock_out ##1 !clock_out ##1 clock_out)
    else $error("clock out");
  chk_pin_reset: assert property (@(posedge clk_sys) disable iff (!resetn)
    !reset_n_pin[*4] |-> in_reset && !phase_one && !data_rd) else $error("pin reset");
  chk_exec_window: assert property (instr_valid && phase_one |=> exec_active[*3] ##1 !exec_active)
    else $error("exec window");
  chk_first_fetch: assert property ($fell(in_reset) |-> phase_one && !instr_valid && !exec_active)
    else $error("first fetch");
  cover property (flush);
  cover property ($fell(in_reset));
  cover property ($rose(clock_out));
  cover property (data_wr);
endmodule // qpipe_chk
bind quad_phase_fetch_execute_pipeline qpipe_chk u_chk (.clk_sys, .resetn, .reset_n_pin, .clock_out, .phase_one,
  .phase_two, .phase_three, .phase_four, .prog_addr, .instr_word, .instr_valid, .data_rd, .data_wr, .branch_req,
  .branch_target, .wr_req, .flush, .in_reset, .exec_active);

// ===== verification/tb.sv
// self-checking bench for the quad phase pipeline
// assumes the pipeline and its checker are compiled first
`timescale 1ns/1ps
module tb;
  logic clk_sys = 0, resetn = 0, reset_n_pin = 0, rc_mode = 0, branch_req = 0, wr_req = 0, bb = 0, br = 0, p4d = 0;
  logic co_q = 0;
  logic [10:0] branch_target = 0;
  logic [11:0] prog_data = 0;
  logic [12:0] ir_e = 0;
  logic [10:0] pc_e = 0, a_e = 0, t_e = 0;
  wire clock_out, phase_one, phase_two, phase_three, phase_four, instr_valid, exec_active, data_rd, data_wr;
  wire flush, in_reset;
  wire [10:0] prog_addr;
  wire [11:0] instr_word;
  integer failures = 0, check_count = 0, seed = 41243, rises = 0, r0;
  quad_phase_fetch_execute_pipeline DUT (.clk_sys, .resetn, .reset_n_pin, .rc_mode, .clock_out, .phase_one,
    .phase_two, .phase_three, .phase_four, .prog_addr, .prog_data, .instr_word, .instr_valid, .exec_active,
    .data_rd, .data_wr, .branch_req, .branch_target, .wr_req, .flush, .in_reset);
  task automatic chk(input logic [12:0] got, input logic [12:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] %0t bit got %b want %b", $time, got, exp);
    end
  endtask
  function automatic logic [12:0] ir_next(input logic redir, input logic [11:0] word);
    ir_next = redir ? 13'h0 : {1'b1, word};
  endfunction
  function automatic logic [10:0] pc_next(input logic redir, input logic [10:0] tgt, input logic [10:0] pc);
    pc_next = redir ? tgt : pc;
  endfunction
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial forever #2 clk_sys = ~clk_sys;
  initial begin
    #20000;
    failures++;
    tally_and_finish;
  end
  always @(posedge clk_sys) begin
    prog_data <= 12'($random(seed));
    wr_req <= 1'($random(seed));
    branch_req <= bb | (($random(seed) & 7) == 0);
    branch_target <= 11'($random(seed));
    co_q <= clock_out;
    if (clock_out & !co_q) rises <= rises + 1;
    if (in_reset) begin
      ir_e <= 13'h0;
      br <= 1'b0;
      p4d <= 1'b0;
      pc_e <= 11'h7ff;
      a_e <= 11'h7ff;
    end else begin
      if (p4d) chk({instr_valid, instr_word}, ir_e);
      if (phase_two) chk({12'h0, data_rd}, {12'h0, ir_e[12]});
      if (phase_four) chk({12'h0, flush}, {12'h0, br});
      if (phase_two) chk({2'h0, prog_addr}, {2'h0, a_e});
      if (phase_four) chk_bit(data_wr, ir_e[12] & wr_req);
      chk_bit(exec_active, ir_e[12] & (phase_two | phase_three | phase_four));
      p4d <= phase_four;
      if (phase_one) a_e <= pc_e;
      if (phase_one) pc_e <= pc_e + 11'h001;
      if (phase_three) br <= branch_req & ir_e[12];
      if (phase_three) t_e <= branch_target;
      if (phase_four) pc_e <= pc_next(br, t_e, pc_e);
      if (phase_four) ir_e <= ir_next(br, prog_data);
    end
  end
  initial begin
    repeat (10) @(posedge clk_sys);
    resetn <= 1;
    repeat (3) @(posedge clk_sys);
    reset_n_pin <= 1;
    repeat (400) @(posedge clk_sys);
    $display("random run done");
    bb <= 1;
    repeat (60) @(posedge clk_sys);
    bb <= 0;
    $display("branch run done");
    for (int m = 0; m < 2; m++) begin
      reset_n_pin <= 0;
      rc_mode <= m[0];
      repeat (6) @(posedge clk_sys);
      chk({12'h0, in_reset}, 13'h1);
      reset_n_pin <= 1;
      repeat (10) @(posedge clk_sys);
      r0 = rises;
      repeat (40) @(posedge clk_sys);
      chk(13'(rises - r0), m ? 13'ha : 13'h0);
      $display("mode run done");
    end
    tally_and_finish;
  end
endmodule // tb
